/* dv/rsr_fetch_model.sv */
`timescale 1ns/10ps
module rsr_fetch_model
  import rsr_pkg::*;
(
  input wire logic i_sys_clk,
  output logic o_valid,
  output logic [INS_W-1:0] o_instr,
  output logic [PC_W-1:0] o_stk
);
  initial
  begin
    o_valid = 1'b0;
    o_instr = 16'h0000;
    o_stk = 11'h000;
  end
  task automatic issue(input logic [INS_W-1:0] ins, input logic [PC_W-1:0] stk);
    @(posedge i_sys_clk);
    #1;
    o_valid = 1'b1;
    o_instr = ins;
    o_stk = stk;
  endtask
  // idle words flip so a stale value never looks held
  task automatic idle();
    @(posedge i_sys_clk);
    #1;
    o_valid = 1'b0;
    o_instr = ~o_instr;
    o_stk = ~o_stk;
  endtask
endmodule

/* dv/test_rotate_subtract_return_ops.sv */
`timescale 1ns/10ps
module test_rotate_subtract_return_ops
  import rsr_pkg::*;
;
  logic clk, rstn, pop, wr, carry, zero, upd;
  logic [NIB_W-1:0] accum, res, mem [MEM_DEPTH];
  logic [PC_W-1:0] pc;
  logic [ADDR_W-1:0] wad;
  logic [NIB_W-1:0] wdat;
  logic [29:0] q[$];
  wire vld;
  wire [INS_W-1:0] ins;
  wire [PC_W-1:0] stk, o_pc;
  wire [NIB_W-1:0] o_accum, o_mdat;
  wire [ADDR_W-1:0] o_madr;
  wire o_carry, o_zero, o_pop, o_done, o_mwr;
  wire [29:0] got = {o_accum, o_carry, o_zero, o_pc, o_pop, o_mwr, o_madr, o_mdat};
  int error_cnt = 0, n_tests = 0, seed = 44889;
  logic [31:0] r;
  logic [15:0] w;
  rsr_fetch_model fm (.i_sys_clk(clk), .o_valid(vld), .o_instr(ins), .o_stk(stk));
  rsr_core dut (.i_sys_clk(clk), .i_rstn(rstn), .i_instr_valid(vld), .i_instr(ins),
    .i_stack_top(stk), .o_accumulator(o_accum), .o_carry_flag(o_carry), .o_zero_flag(o_zero),
    .o_pc(o_pc), .o_stack_pop(o_pop), .o_done(o_done), .o_mem_wr(o_mwr),
    .o_mem_addr(o_madr), .o_mem_data(o_mdat));
  task automatic chk(input logic [29:0] e);
    n_tests++;
    if (got !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED outputs exp %h got %h", e, got);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic store(input logic [ADDR_W-1:0] a);
    wr = 1'b1;
    wad = a;
    wdat = res;
    mem[a] = res;
  endtask
  // reference steps one instruction ahead of the core
  task automatic exec(input logic [15:0] i, input logic [PC_W-1:0] s);
    logic [4:0] d;
    logic [ADDR_W-1:0] a;
    a = i[6:0];
    {pop, wr, upd} = 3'b001;
    if (i[15:7] == OP_ROT_RIGHT_CARRY)
    begin
      res = {carry, mem[a][3:1]};
      carry = mem[a][0];
      store(a);
    end
    else if (i == OP_SUBROUTINE_RETURN)
    begin
      {pc, pop, upd} = {s, 2'b10};
    end
    else if (i[15:7] == OP_SUB_BORROW_MEM || i[15:7] == OP_SUB_BORROW_STORE_MEM)
    begin
      d = {1'b0, mem[a]} - {1'b0, accum} - carry;
      {carry, res} = d;
      if (i[15:7] == OP_SUB_BORROW_STORE_MEM)
        store(a);
    end
    else if (i[15:8] == OP_SUB_BORROW_IMM || i[15:8] == OP_SUB_BORROW_STORE_IMM)
    begin
      a = {3'h0, i[3:0]};
      d = {1'b0, mem[a]} - {1'b0, i[7:4]} - carry;
      {carry, res} = d;
      if (i[15:8] == OP_SUB_BORROW_STORE_IMM)
        store(a);
    end
    else
      upd = 1'b0;
    if (upd)
    begin
      accum = res;
      zero = (res == 4'h0);
    end
    q.push_back({accum, carry, zero, pc, pop, wr, wad, wdat});
    fm.issue(i, s);
  endtask
  // reference state after any reset: outputs and data memory all zero
  task automatic ref_reset();
    {accum, carry, zero, pc, wad, wdat} = '0;
    foreach (mem[k])
      mem[k] = 4'h0;
  endtask
  task automatic run_random(input int n);
    repeat (n)
    begin
      r = $random(seed);
      case (r[18:16])
        3'd0: w = {OP_ROT_RIGHT_CARRY, r[6:0]};
        3'd1: w = OP_SUBROUTINE_RETURN;
        3'd2: w = {OP_SUB_BORROW_MEM, r[6:0]};
        3'd3: w = {OP_SUB_BORROW_STORE_MEM, r[6:0]};
        3'd4: w = {OP_SUB_BORROW_IMM, r[7:0]};
        3'd7: w = {4'hF, r[11:0]};
        default: w = {OP_SUB_BORROW_STORE_IMM, r[7:0]};
      endcase
      if (r[15] & r[14])
        fm.idle();
      exec(w, r[30:20]);
    end
    fm.idle();
  endtask
  always @(negedge clk)
    if (rstn && o_done === 1'b1)
    begin
      if (q.size() == 0)
      begin
        // a done pulse with nothing issued is always a mismatch
        n_tests++;
        error_cnt++;
        $display("CHECK FAILED done exp none got %h", got);
      end
      else
        chk(q.pop_front());
    end
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    #200000;
    error_cnt++;
    $display("CHECK FAILED watchdog exp done got timeout");
    finish_test();
  end
  initial
  begin
    rstn = 1'b0;
    ref_reset();
    repeat (10) @(posedge clk);
    #1;
    rstn = 1'b1;
    @(negedge clk);
    chk(30'h0);
    exec(16'h4D85, 11'h7FF);
    run_random(400);
    // second reset in mid-run: memory must come back cleared
    repeat (2) @(posedge clk);
    #1;
    rstn = 1'b0;
    ref_reset();
    repeat (3) @(posedge clk);
    #1;
    rstn = 1'b1;
    @(negedge clk);
    chk(30'h0);
    exec(16'h4D85, 11'h7FF);
    run_random(40);
    repeat (3) @(negedge clk);
    n_tests++;
    if (q.size() != 0)
    begin
      error_cnt++;
      $display("CHECK FAILED pending exp 0 got %0d", q.size());
    end
    finish_test();
  end
endmodule

/* verilog/rsr_core.sv */
// Contract
// - decode rotate-right prefix, one cycle
// - rotate nibble through carry, store memory+accumulator
// - return reloads eleven-bit pc, flags kept
// - memory minus accumulator minus carry, accumulator only
// - register minus immediate minus carry, accumulator only
// - memory subtract stored to accumulator and memory
// - register subtract stored to accumulator and register
`timescale 1ns/10ps
module rsr_core
  import rsr_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_instr_valid,
  input wire logic [INS_W-1:0] i_instr,
  input wire logic [PC_W-1:0] i_stack_top,
  output logic [NIB_W-1:0] o_accumulator,
  output logic o_carry_flag,
  output logic o_zero_flag,
  output logic [PC_W-1:0] o_pc,
  output logic o_stack_pop,
  output logic o_done,
  output logic o_mem_wr,
  output logic [ADDR_W-1:0] o_mem_addr,
  output logic [NIB_W-1:0] o_mem_data
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [MEM_DEPTH-1:0][NIB_W-1:0] ram;
    logic [NIB_W-1:0] accumulator;
    logic carry_flag;
    logic zero_flag;
    logic [PC_W-1:0] pc;
    logic pop;
    logic done;
    logic mem_wr;
    logic [ADDR_W-1:0] mem_addr;
    logic [NIB_W-1:0] mem_data;
  } rsr_state_t;

  rsr_state_t s_q;
  rsr_state_t s_d;

  logic [ADDR_W-1:0] mem_addr;
  logic [ADDR_W-1:0] wr_addr;
  logic [NIB_W-1:0] imm;
  logic [NIB_W-1:0] opnd_mem;
  logic [NIB_W-1:0] opnd_wr;
  logic rotate_right_carry_op;
  logic subroutine_return_op;
  logic sub_mem_op;
  logic sub_imm_op;
  logic sub_store_mem_op;
  logic sub_store_imm_op;
  logic [NIB_W:0] diff_mem;
  logic [NIB_W:0] diff_imm;
  logic [NIB_W-1:0] rot_res;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  assign mem_addr = i_instr[ADDR_MSB:0];
  assign wr_addr = {{(ADDR_W-WR_W){1'b0}}, i_instr[WRF_MSB:0]};
  assign imm = i_instr[IMM_MSB:IMM_LSB];
  assign opnd_mem = s_q.ram[mem_addr];
  assign opnd_wr = s_q.ram[wr_addr];

  assign rotate_right_carry_op = i_instr[INS_W-1:OP9_LSB] == OP_ROT_RIGHT_CARRY;
  assign subroutine_return_op = i_instr == OP_SUBROUTINE_RETURN;
  assign sub_mem_op = i_instr[INS_W-1:OP9_LSB] == OP_SUB_BORROW_MEM;
  assign sub_store_mem_op = i_instr[INS_W-1:OP9_LSB] == OP_SUB_BORROW_STORE_MEM;
  assign sub_imm_op = i_instr[INS_W-1:OP8_LSB] == OP_SUB_BORROW_IMM;
  assign sub_store_imm_op = i_instr[INS_W-1:OP8_LSB] == OP_SUB_BORROW_STORE_IMM;

  // ----------------------------------------
  // datapath
  // ----------------------------------------
  // top bit of the 5-bit difference is the borrow out
  assign diff_mem = {1'b0, opnd_mem} - {1'b0, s_q.accumulator}
                    - {{NIB_W{1'b0}}, s_q.carry_flag};
  assign diff_imm = {1'b0, opnd_wr} - {1'b0, imm} - {{NIB_W{1'b0}}, s_q.carry_flag};
  assign rot_res = {s_q.carry_flag, opnd_mem[NIB_W-1:1]};

  always_comb
  begin
    s_d = s_q;
    s_d.pop = 1'b0;
    s_d.done = 1'b0;
    s_d.mem_wr = 1'b0;
    if (i_instr_valid)
    begin
      // one instruction retires per clock, no multi-cycle path
      s_d.done = 1'b1;
      if (rotate_right_carry_op)
      begin
        s_d.accumulator = rot_res;
        s_d.carry_flag = opnd_mem[0];
        s_d.zero_flag = rot_res == NIB_ZERO;
        s_d.ram[mem_addr] = rot_res;
        s_d.mem_wr = 1'b1;
        s_d.mem_addr = mem_addr;
        s_d.mem_data = rot_res;
      end
      else if (subroutine_return_op)
      begin
        s_d.pc = i_stack_top;
        s_d.pop = 1'b1;
      end
      else if (sub_mem_op || sub_store_mem_op)
      begin
        s_d.accumulator = diff_mem[NIB_W-1:0];
        s_d.carry_flag = diff_mem[NIB_W];
        s_d.zero_flag = diff_mem[NIB_W-1:0] == NIB_ZERO;
        if (sub_store_mem_op)
        begin
          s_d.ram[mem_addr] = diff_mem[NIB_W-1:0];
          s_d.mem_wr = 1'b1;
          s_d.mem_addr = mem_addr;
          s_d.mem_data = diff_mem[NIB_W-1:0];
        end
      end
      else if (sub_imm_op || sub_store_imm_op)
      begin
        s_d.accumulator = diff_imm[NIB_W-1:0];
        s_d.carry_flag = diff_imm[NIB_W];
        s_d.zero_flag = diff_imm[NIB_W-1:0] == NIB_ZERO;
        if (sub_store_imm_op)
        begin
          s_d.ram[wr_addr] = diff_imm[NIB_W-1:0];
          s_d.mem_wr = 1'b1;
          s_d.mem_addr = wr_addr;
          s_d.mem_data = diff_imm[NIB_W-1:0];
        end
      end
      else
      begin
        // opcodes outside this block retire with no effect here
        s_d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rstn)
    begin
      s_q <= '0;
      s_q.pc <= PC_RESET;
      s_q.carry_flag <= FLAG_RESET;
      s_q.zero_flag <= FLAG_RESET;
      s_q.mem_addr <= ADDR_ZERO;
      s_q.mem_data <= NIB_ZERO;
      s_q.accumulator <= NIB_ZERO;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign o_accumulator = s_q.accumulator;
  assign o_carry_flag = s_q.carry_flag;
  assign o_zero_flag = s_q.zero_flag;
  assign o_pc = s_q.pc;
  assign o_stack_pop = s_q.pop;
  assign o_done = s_q.done;
  assign o_mem_wr = s_q.mem_wr;
  assign o_mem_addr = s_q.mem_addr;
  assign o_mem_data = s_q.mem_data;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_ONE_CYCLE: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    i_instr_valid |=> o_done ##1 (o_done == $past(i_instr_valid)))
    else $error("instruction did not retire in one cycle");

  AST_ROT_VALUE: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (i_instr_valid && rotate_right_carry_op) |=>
      (o_accumulator == {$past(s_q.carry_flag), $past(opnd_mem[NIB_W-1:1])})
      && (o_carry_flag == $past(opnd_mem[0])))
    else $error("rotate right through carry wrong");

  AST_ROT_STORE: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (i_instr_valid && rotate_right_carry_op) |=>
      o_mem_wr && (o_mem_addr == $past(mem_addr)) && (s_q.ram[o_mem_addr] == o_accumulator))
    else $error("rotate result not stored");

  AST_RETURN_PC: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (i_instr_valid && subroutine_return_op) |=>
      (o_pc == $past(i_stack_top)) && o_stack_pop && !o_mem_wr
      && $stable(o_carry_flag) && $stable(o_zero_flag))
    else $error("return did not restore pc or touched flags");

  AST_SUB_MEM: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (i_instr_valid && sub_mem_op) |=>
      ({o_carry_flag, o_accumulator} == $past(diff_mem)) && !o_mem_wr
      && (s_q.ram == $past(s_q.ram)))
    else $error("memory subtract wrong or memory changed");

  AST_SUB_IMM: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (i_instr_valid && sub_imm_op) |=>
      (o_accumulator == 4'(($past(opnd_wr) - $past(imm)) - {3'h0, $past(s_q.carry_flag)}))
      && !o_mem_wr)
    else $error("immediate subtract wrong");

  AST_SUB_STORE_MEM: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (i_instr_valid && sub_store_mem_op) |=>
      o_mem_wr && (o_mem_addr == $past(mem_addr)) && (o_mem_data == o_accumulator)
      && (s_q.ram[o_mem_addr] == $past(diff_mem[NIB_W-1:0])))
    else $error("memory subtract not stored back");

  AST_SUB_STORE_IMM: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (i_instr_valid && sub_store_imm_op) |=>
      o_mem_wr && (o_mem_addr == $past(wr_addr)) && (o_carry_flag == $past(diff_imm[NIB_W]))
      && (s_q.ram[o_mem_addr] == o_accumulator))
    else $error("register subtract not stored back");

  AST_ZERO_FLAG: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (i_instr_valid && (rotate_right_carry_op || sub_mem_op || sub_imm_op
      || sub_store_mem_op || sub_store_imm_op)) |=> (o_zero_flag == (o_accumulator == NIB_ZERO)))
    else $error("zero flag does not match result");

endmodule

/* verilog/rsr_pkg.sv */
package rsr_pkg;
  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int NIB_W = 4;
  localparam int ADDR_W = 7;
  localparam int WR_W = 4;
  localparam int PC_W = 11;
  localparam int INS_W = 16;
  localparam int MEM_DEPTH = 128;
  // ----------------------------------------
  // instruction field positions
  // ----------------------------------------
  localparam int OP9_LSB = 7;
  localparam int OP8_LSB = 8;
  localparam int ADDR_MSB = 6;
  localparam int IMM_MSB = 7;
  localparam int IMM_LSB = 4;
  localparam int WRF_MSB = 3;
  // ----------------------------------------
  // opcode prefixes, and the full 16-bit return opcode
  // ----------------------------------------
  localparam logic [8:0] OP_ROT_RIGHT_CARRY = 9'h09B;
  localparam logic [8:0] OP_SUB_BORROW_MEM = 9'h028;
  localparam logic [8:0] OP_SUB_BORROW_STORE_MEM = 9'h016;
  localparam logic [7:0] OP_SUB_BORROW_IMM = 8'h0E;
  localparam logic [7:0] OP_SUB_BORROW_STORE_IMM = 8'h0F;
  localparam logic [15:0] OP_SUBROUTINE_RETURN = 16'h0080;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [NIB_W-1:0] NIB_ZERO = 4'h0;
  localparam logic [PC_W-1:0] PC_RESET = 11'h000;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 7'h00;
  localparam logic FLAG_RESET = 1'b0;
endpackage
